// ### verilog/ssd_pkg.sv
// Shared register map, field positions and reset values for the serial data/status block
package ssd_pkg;
  // Byte addresses of the word registers
  localparam logic [5:0] ADDR_THR = 6'h00;
  localparam logic [5:0] ADDR_RSHR = 6'h04;
  localparam logic [5:0] ADDR_TSHR = 6'h08;
  localparam logic [5:0] ADDR_SR = 6'h0C;
  localparam logic [5:0] ADDR_IER = 6'h10;
  localparam logic [5:0] ADDR_IDR = 6'h14;
  localparam logic [5:0] ADDR_IMR = 6'h18;
  localparam logic [5:0] ADDR_CTRL = 6'h1C;
  localparam logic [5:0] ADDR_RHR = 6'h20;
  // Status and interrupt bit positions
  localparam int SR_TX_READY = 0;
  localparam int SR_TX_EMPTY = 1;
  localparam int SR_TX_DMA_DONE = 2;
  localparam int SR_TX_BUFS_EMPTY = 3;
  localparam int SR_RX_READY = 4;
  localparam int SR_RX_OVERRUN = 5;
  localparam int SR_RX_DMA_DONE = 6;
  localparam int SR_RX_BUFS_FULL = 7;
  localparam int SR_TX_SYNC = 10;
  localparam int SR_RX_SYNC = 11;
  localparam int SR_TX_ENABLED = 16;
  localparam int SR_RX_ENABLED = 17;
  // Interrupt source bits that exist
  localparam logic [31:0] IRQ_BITS = 32'h00000CFF;
  // Control register fields
  localparam int CTRL_TX_ENABLE = 0;
  localparam int CTRL_RX_ENABLE = 1;
  localparam int CTRL_SDEN = 2;
  localparam int CTRL_IDLE = 3;
  localparam int CTRL_WLEN_LSB = 8;
  localparam int CTRL_SLEN_LSB = 16;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000001F;
  localparam logic [31:0] IMR_RESET = 32'h00000000;
  localparam logic [15:0] SYNC_RESET = 16'h0000;
  // Transmit shifter states
  typedef enum logic [1:0] {
    SSD_IDLE = 2'b00,
    SSD_SYNC = 2'b01,
    SSD_DATA = 2'b10
  } ssd_tx_state_type;
endpackage

// ### verilog/ssd_edge_sync.sv
// Two-flop synchroniser for an outside pin with rise and fall detection
module ssd_edge_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta_ff; // First stage, read only by the second
  logic sync_ff; // Second stage, safe to use
  logic last_ff; // Previous synchronised level
  logic nxt_meta, nxt_sync, nxt_last;

  // Next values of the chain
  always_comb begin
    nxt_meta = pin;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  // Register the chain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // Edges seen only after both stages
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule

// ### verilog/ssd_tx_shift.sv
// Transmit shifter: sync period then one data word, MSB first, one bit per link edge
module ssd_tx_shift
  import ssd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic bit_en,
  input wire logic start,
  input wire logic [31:0] word,
  input wire logic [15:0] sync_word,
  input wire logic [4:0] word_length,
  input wire logic [3:0] sync_length,
  input wire logic sync_data_enable,
  input wire logic idle_level,
  output logic take,
  output logic busy,
  output logic sync_pulse,
  output logic tx_data_ff,
  output logic tx_frame_ff
);
  ssd_tx_state_type state_ff, nxt_state; // Phase of the frame
  logic [4:0] cnt_ff, nxt_cnt; // Index of the bit on the line
  logic [31:0] sh_ff, nxt_sh; // Captured word
  logic nxt_data, nxt_frame;
  logic begin_frame; // Start a new frame on this edge

  // Frame sequencing; a waiting word starts right after the last bit
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_data = tx_data_ff;
    nxt_frame = tx_frame_ff;
    begin_frame = 1'b0;
    if (bit_en) begin
      case (state_ff)
        SSD_IDLE: begin
          begin_frame = start;
        end
        SSD_SYNC: begin
          if (cnt_ff == 5'h00) begin
            nxt_state = SSD_DATA;
            nxt_cnt = word_length;
            nxt_data = sh_ff[word_length];
            nxt_frame = 1'b0;
          end else begin
            nxt_cnt = cnt_ff - 5'h01;
            // Sync bits only when enabled, else the idle level
            nxt_data = sync_data_enable ? sync_word[nxt_cnt[3:0]] : idle_level;
          end
        end
        SSD_DATA: begin
          if (cnt_ff != 5'h00) begin
            nxt_cnt = cnt_ff - 5'h01;
            nxt_data = sh_ff[nxt_cnt];
          end else begin
            begin_frame = start;
            nxt_state = SSD_IDLE;
            nxt_data = idle_level;
          end
        end
        default: nxt_state = SSD_IDLE;
      endcase
      if (begin_frame) begin
        nxt_state = SSD_SYNC;
        nxt_sh = word;
        nxt_cnt = {1'b0, sync_length};
        nxt_frame = 1'b1;
        nxt_data = sync_data_enable ? sync_word[sync_length] : idle_level;
      end
    end
    if (state_ff == SSD_IDLE && !begin_frame) begin
      nxt_data = idle_level;
    end
  end

  // Register the shifter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= SSD_IDLE;
      cnt_ff <= 5'h00;
      sh_ff <= 32'h00000000;
      tx_data_ff <= 1'b0;
      tx_frame_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      tx_data_ff <= nxt_data;
      tx_frame_ff <= nxt_frame;
    end
  end

  assign take = begin_frame;
  assign sync_pulse = begin_frame;
  assign busy = (state_ff != SSD_IDLE);
endmodule

// ### verilog/ssd_serial_regs.sv
// Holding, status and interrupt registers of the sync serial controller, Avalon-MM slave
module ssd_serial_regs
  import ssd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic tx_clk_pin,
  input wire logic rx_frame_pin,
  output logic tx_data_pin,
  output logic tx_frame_pin,
  input wire logic rx_load,
  input wire logic [31:0] rx_word,
  input wire logic tx_cnt_zero,
  input wire logic tx_next_zero,
  input wire logic tx_cnt_wr,
  input wire logic rx_cnt_zero,
  input wire logic rx_next_zero,
  input wire logic rx_cnt_wr
);
  // Bus handshake state
  logic ack_ff, nxt_ack; // Second cycle of an access
  logic [31:0] rdata_ff, nxt_rdata; // Read data, captured in first cycle
  logic done; // Access completes on this edge
  logic wr_done, rd_done;
  // Register state
  logic hold_full_ff, nxt_hold_full; // Transmit word waiting
  logic [31:0] hold_word_ff, nxt_hold_word; // Transmit word
  logic [15:0] rsync_ff, nxt_rsync; // Receive sync word
  logic [15:0] tsync_ff, nxt_tsync; // Transmit sync word
  logic [31:0] ctrl_ff, nxt_ctrl; // Enables and frame format
  logic [31:0] imr_ff, nxt_imr; // Interrupt enables
  logic [31:0] rhr_ff, nxt_rhr; // Received word
  logic rx_ready_ff, nxt_rx_ready;
  logic overrun_ff, nxt_overrun;
  logic end_tx_ff, nxt_end_tx;
  logic end_rx_ff, nxt_end_rx;
  logic tx_sync_ff, nxt_tx_sync;
  logic rx_sync_ff, nxt_rx_sync;
  logic irq_ff, nxt_irq;
  logic irq_src; // Some enabled flag is set now
  // Link side
  logic clk_fall; // Link clock falling edge, one bit time
  logic rx_frame_rise; // Receive frame start
  logic tx_take, tx_busy, tx_sync_pulse;
  logic [31:0] status; // Live status word

  // Address match, used by read and write decode
  function automatic logic is_addr(input logic [5:0] a, input logic [5:0] r);
    is_addr = (a == r);
  endfunction

  // Link clock is sampled; data changes on its falling edge
  ssd_edge_sync u_clk_sync (
    .clock(clock),
    .rst(rst),
    .pin(tx_clk_pin),
    .rise(),
    .fall(clk_fall)
  );

  // Receive frame pin rising edge is the receive sync event
  ssd_edge_sync u_rxf_sync (
    .clock(clock),
    .rst(rst),
    .pin(rx_frame_pin),
    .rise(rx_frame_rise),
    .fall()
  );

  // Shifter pulls the held word only while transmit is enabled
  ssd_tx_shift u_tx (
    .clock(clock),
    .rst(rst),
    .bit_en(clk_fall),
    .start(hold_full_ff & ctrl_ff[CTRL_TX_ENABLE]),
    .word(hold_word_ff),
    .sync_word(tsync_ff),
    .word_length(ctrl_ff[CTRL_WLEN_LSB +: 5]),
    .sync_length(ctrl_ff[CTRL_SLEN_LSB +: 4]),
    .sync_data_enable(ctrl_ff[CTRL_SDEN]),
    .idle_level(ctrl_ff[CTRL_IDLE]),
    .take(tx_take),
    .busy(tx_busy),
    .sync_pulse(tx_sync_pulse),
    .tx_data_ff(tx_data_pin),
    .tx_frame_ff(tx_frame_pin)
  );

  // Status word assembled from live flags
  always_comb begin
    status = 32'h00000000;
    status[SR_TX_READY] = ~hold_full_ff;
    status[SR_TX_EMPTY] = ~hold_full_ff & ~tx_busy;
    status[SR_TX_DMA_DONE] = end_tx_ff;
    status[SR_TX_BUFS_EMPTY] = tx_cnt_zero & tx_next_zero;
    status[SR_RX_READY] = rx_ready_ff;
    status[SR_RX_OVERRUN] = overrun_ff;
    status[SR_RX_DMA_DONE] = end_rx_ff;
    status[SR_RX_BUFS_FULL] = rx_cnt_zero & rx_next_zero;
    status[SR_TX_SYNC] = tx_sync_ff;
    status[SR_RX_SYNC] = rx_sync_ff;
    status[SR_TX_ENABLED] = ctrl_ff[CTRL_TX_ENABLE];
    status[SR_RX_ENABLED] = ctrl_ff[CTRL_RX_ENABLE];
  end

  // Bus: every access takes two cycles, waitrequest low in the second
  always_comb begin
    nxt_ack = (read | write) & ~ack_ff;
    nxt_rdata = rdata_ff;
    // Capture in first cycle so data is steady at the completing edge
    if (read && !ack_ff) begin
      if (is_addr(address, ADDR_RSHR)) begin
        nxt_rdata = {16'h0000, rsync_ff};
      end else if (is_addr(address, ADDR_TSHR)) begin
        nxt_rdata = {16'h0000, tsync_ff};
      end else if (is_addr(address, ADDR_SR)) begin
        nxt_rdata = status;
      end else if (is_addr(address, ADDR_IMR)) begin
        nxt_rdata = imr_ff;
      end else if (is_addr(address, ADDR_CTRL)) begin
        nxt_rdata = ctrl_ff;
      end else if (is_addr(address, ADDR_RHR)) begin
        nxt_rdata = rhr_ff;
      end else begin
        // Write-only and unmapped words read as zero
        nxt_rdata = 32'h00000000;
      end
    end
  end

  // Register the bus handshake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign waitrequest = (read | write) & ~ack_ff;
  assign readdata = rdata_ff;
  assign done = (read | write) & ack_ff;
  assign wr_done = done & write;
  assign rd_done = done & read;

  // Register updates; a hardware set always beats a clear in the same cycle
  always_comb begin
    nxt_hold_full = hold_full_ff;
    nxt_hold_word = hold_word_ff;
    nxt_rsync = rsync_ff;
    nxt_tsync = tsync_ff;
    nxt_ctrl = ctrl_ff;
    nxt_imr = imr_ff;
    nxt_rhr = rhr_ff;
    // Shifter takes the held word; a new write refills it
    if (tx_take) begin
      nxt_hold_full = 1'b0;
    end
    if (wr_done && is_addr(address, ADDR_THR)) begin
      nxt_hold_word = writedata;
      nxt_hold_full = 1'b1;
    end
    if (wr_done && is_addr(address, ADDR_RSHR)) begin
      nxt_rsync = writedata[15:0];
    end
    if (wr_done && is_addr(address, ADDR_TSHR)) begin
      nxt_tsync = writedata[15:0];
    end
    if (wr_done && is_addr(address, ADDR_CTRL)) begin
      nxt_ctrl = writedata;
    end
    if (wr_done && is_addr(address, ADDR_IER)) begin
      nxt_imr = imr_ff | (writedata & IRQ_BITS);
    end
    if (wr_done && is_addr(address, ADDR_IDR)) begin
      nxt_imr = imr_ff & ~writedata;
    end
    // Receive word: reading the holding word empties it
    nxt_rx_ready = rx_ready_ff & ~(rd_done && is_addr(address, ADDR_RHR));
    if (rx_load) begin
      nxt_rhr = rx_word;
      nxt_rx_ready = 1'b1;
    end
    // Status read clears overrun and sync flags; new events still land
    nxt_overrun = (overrun_ff & ~(rd_done && is_addr(address, ADDR_SR))) | (rx_load & rx_ready_ff);
    nxt_tx_sync = (tx_sync_ff & ~(rd_done && is_addr(address, ADDR_SR))) | tx_sync_pulse;
    nxt_rx_sync = (rx_sync_ff & ~(rd_done && is_addr(address, ADDR_SR))) | rx_frame_rise;
    // Counter writes re-arm the end flags
    nxt_end_tx = (end_tx_ff & ~tx_cnt_wr) | tx_cnt_zero;
    nxt_end_rx = (end_rx_ff & ~rx_cnt_wr) | rx_cnt_zero;
    // Interrupt registered from the live status flags, one cycle behind status
    nxt_irq = irq_src;
  end

  // Register all state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_full_ff <= 1'b0;
      hold_word_ff <= 32'h00000000;
      rsync_ff <= SYNC_RESET;
      tsync_ff <= SYNC_RESET;
      ctrl_ff <= CTRL_RESET;
      imr_ff <= IMR_RESET;
      rhr_ff <= 32'h00000000;
      rx_ready_ff <= 1'b0;
      overrun_ff <= 1'b0;
      end_tx_ff <= 1'b0;
      end_rx_ff <= 1'b0;
      tx_sync_ff <= 1'b0;
      rx_sync_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      hold_full_ff <= nxt_hold_full;
      hold_word_ff <= nxt_hold_word;
      rsync_ff <= nxt_rsync;
      tsync_ff <= nxt_tsync;
      ctrl_ff <= nxt_ctrl;
      imr_ff <= nxt_imr;
      rhr_ff <= nxt_rhr;
      rx_ready_ff <= nxt_rx_ready;
      overrun_ff <= nxt_overrun;
      end_tx_ff <= nxt_end_tx;
      end_rx_ff <= nxt_end_rx;
      tx_sync_ff <= nxt_tx_sync;
      rx_sync_ff <= nxt_rx_sync;
      irq_ff <= nxt_irq;
    end
  end

  assign irq = irq_ff;
  // Raw source of the interrupt, registered before it leaves
  assign irq_src = |(status & imr_ff);

  // A completed word write leaves transmit ready low
  property p_thr_full;
    @(posedge clock) disable iff (rst)
    (wr_done && address == ADDR_THR) |=> !status[SR_TX_READY];
  endproperty
  a_thr_full: assert property (p_thr_full) else $error("tx ready high after word write");

  // Never empty while shifting
  property p_empty_busy;
    @(posedge clock) disable iff (rst)
    tx_busy |-> !status[SR_TX_EMPTY];
  endproperty
  a_empty_busy: assert property (p_empty_busy) else $error("tx empty while busy");

  // Counter zero flags end of transmission next cycle and stays until write
  property p_end_tx;
    @(posedge clock) disable iff (rst)
    (tx_cnt_zero ##1 !tx_cnt_wr) |=> end_tx_ff;
  endproperty
  a_end_tx: assert property (p_end_tx) else $error("end of transmission lost");

  // Buffer flags follow both counters
  property p_bufs;
    @(posedge clock) disable iff (rst)
    1'b1 |-> (status[SR_RX_BUFS_FULL] == (rx_cnt_zero && rx_next_zero)) &&
      (status[SR_TX_BUFS_EMPTY] == (tx_cnt_zero && tx_next_zero));
  endproperty
  a_bufs: assert property (p_bufs) else $error("buffer flag mismatch");

  // Load over an unread word raises overrun
  property p_overrun;
    @(posedge clock) disable iff (rst)
    (rx_load && rx_ready_ff) |=> overrun_ff && rx_ready_ff;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  // Counter write without new zero clears end of reception
  property p_end_rx;
    @(posedge clock) disable iff (rst)
    (rx_cnt_wr && !rx_cnt_zero) |=> !end_rx_ff;
  endproperty
  a_end_rx: assert property (p_end_rx) else $error("end of reception not cleared");

  // Status read with no new event clears tx sync
  property p_sync_clr;
    @(posedge clock) disable iff (rst)
    (rd_done && address == ADDR_SR && !tx_sync_pulse) |=> !tx_sync_ff;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("tx sync not cleared by read");

  // Enable write sets exactly the written bits that are in IRQ_BITS
  property p_ier;
    @(posedge clock) disable iff (rst)
    (wr_done && address == ADDR_IER) |=> imr_ff == ($past(imr_ff) | ($past(writedata) & IRQ_BITS));
  endproperty
  a_ier: assert property (p_ier) else $error("enable write wrong");

  // Disable write clears the written bits
  property p_idr;
    @(posedge clock) disable iff (rst)
    (wr_done && address == ADDR_IDR) |=> (imr_ff & $past(writedata)) == 32'h00000000;
  endproperty
  a_idr: assert property (p_idr) else $error("disable write wrong");

  // Interrupt follows enabled flags one cycle later
  property p_irq;
    @(posedge clock) disable iff (rst)
    1'b1 |=> irq == $past(irq_src);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");
endmodule

// ### test/ssd_far_model.sv
// Far-side model: link clock, receive feed, DMA counter levels and serial capture
module ssd_far_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic tx_data_pin,
  input wire logic tx_frame_pin,
  output logic tx_clk_pin,
  output logic rx_frame_pin,
  output logic rx_load,
  output logic [31:0] rx_word,
  output logic tx_cnt_zero,
  output logic tx_next_zero,
  output logic tx_cnt_wr,
  output logic rx_cnt_zero,
  output logic rx_next_zero,
  output logic rx_cnt_wr,
  output logic [15:0] seen_data,
  output logic [15:0] seen_frame
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet start: link clock parked high, counters loaded (not zero)
  initial begin
    tx_clk_pin = 1'b1;
    rx_frame_pin = 1'b0;
    rx_load = 1'b0;
    rx_word = 32'hA5A5_5A5A;
    {tx_cnt_zero, tx_next_zero, rx_cnt_zero, rx_next_zero} = 4'h0;
    {tx_cnt_wr, rx_cnt_wr} = 2'h0;
    seen_data = 16'h0;
    seen_frame = 16'h0;
  end

  // Link clock runs only inside this task; lines sampled mid-bit on the rise
  task automatic link_run(input int n);
    // Offset so that no pin edge lands on a system clock edge
    #1;
    for (int i = 0; i < n; i++) begin
      tx_clk_pin = 1'b0;
      #62.5;
      tx_clk_pin = 1'b1;
      seen_data = {seen_data[14:0], tx_data_pin};
      seen_frame = {seen_frame[14:0], tx_frame_pin};
      #62.5;
    end
  endtask

  // One-cycle delivery from the receive shifter
  task automatic rx_deliver(input logic [31:0] w);
    @(posedge clock);
    rx_load <= 1'b1;
    rx_word <= w;
    @(posedge clock);
    rx_load <= 1'b0;
    // Stale word is inverted so a late capture shows up
    rx_word <= ~w;
  endtask

  // Receive frame sync pulse, long enough for the synchroniser
  task automatic rx_sync();
    @(posedge clock);
    rx_frame_pin <= 1'b1;
    repeat (6) @(posedge clock);
    rx_frame_pin <= 1'b0;
  endtask

  // Counter-zero levels of one direction
  task automatic dma_set(input logic rx, input logic c, input logic n);
    @(posedge clock);
    if (rx) {rx_cnt_zero, rx_next_zero} <= {c, n};
    else {tx_cnt_zero, tx_next_zero} <= {c, n};
  endtask

  // Counter register write strobe of one direction
  task automatic dma_wr(input logic rx);
    @(posedge clock);
    if (rx) rx_cnt_wr <= 1'b1;
    else tx_cnt_wr <= 1'b1;
    @(posedge clock);
    {tx_cnt_wr, rx_cnt_wr} <= 2'h0;
  endtask
endmodule

// ### test/sync_serial_data_status_regs_test.sv
// Self-checking bench for the serial holding, status and interrupt registers
module sync_serial_data_status_regs_test
  import ssd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock, rst, read, write, waitrequest, irq;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rx_word, d, r, w;
  logic tx_clk_pin, rx_frame_pin, tx_data_pin, tx_frame_pin, rx_load;
  logic tx_cnt_zero, tx_next_zero, tx_cnt_wr, rx_cnt_zero, rx_next_zero, rx_cnt_wr;
  logic [15:0] seen_data, seen_frame;
  logic [5:0] wo_list [5] = '{ADDR_THR, ADDR_IER, ADDR_IDR, 6'h24, 6'h3C};
  int n_fail = 0;
  int n_checks = 0;
  int seed = 32'hB9D3;
  int cyc = 0;

  ssd_serial_regs ssd_serial_regs_inst (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .tx_clk_pin(tx_clk_pin), .rx_frame_pin(rx_frame_pin), .tx_data_pin(tx_data_pin),
    .tx_frame_pin(tx_frame_pin), .rx_load(rx_load), .rx_word(rx_word), .tx_cnt_zero(tx_cnt_zero),
    .tx_next_zero(tx_next_zero), .tx_cnt_wr(tx_cnt_wr), .rx_cnt_zero(rx_cnt_zero),
    .rx_next_zero(rx_next_zero), .rx_cnt_wr(rx_cnt_wr));

  ssd_far_model ssd_far_model_inst (.clock(clock), .rst(rst), .tx_data_pin(tx_data_pin),
    .tx_frame_pin(tx_frame_pin), .tx_clk_pin(tx_clk_pin), .rx_frame_pin(rx_frame_pin),
    .rx_load(rx_load), .rx_word(rx_word), .tx_cnt_zero(tx_cnt_zero), .tx_next_zero(tx_next_zero),
    .tx_cnt_wr(tx_cnt_wr), .rx_cnt_zero(rx_cnt_zero), .rx_next_zero(rx_next_zero),
    .rx_cnt_wr(rx_cnt_wr), .seen_data(seen_data), .seen_frame(seen_frame));

  // 100 MHz system clock
  always #5 clock = ~clock;

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard; the whole sequence needs under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Single compare point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon access: held until waitrequest is sampled low
  // Only the cycle ceiling ends a wait that never completes
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clock);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= wd;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b0, a, v, x);
  endtask

  // Read and compare the masked bits
  task automatic chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b1, a, 32'h0, x);
    check(x & m, e);
  endtask

  // Expected 13 link bits: 4 sync bits, 8 data bits MSB first, then idle high
  function automatic logic [12:0] exp_frame(input logic sden, input logic [3:0] ts, input logic [7:0] wd);
    return {(sden ? ts : 4'hF), wd, 1'b1};
  endfunction

  // Main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {read, write, address, writedata} = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Reset view: transmitter idle, both directions enabled, no sources enabled
    chk(ADDR_SR, 32'h0003_0CBB, 32'h0003_0003);
    chk(ADDR_IMR, 32'hFFFF_FFFF, 32'h0);
    foreach (wo_list[i]) chk(wo_list[i], 32'hFFFF_FFFF, 32'h0);
    // Sync holding words keep only the low half
    repeat (4) begin
      r = $random(seed);
      wr(ADDR_RSHR, r);
      wr(ADDR_TSHR, ~r);
      chk(ADDR_RSHR, 32'hFFFF_FFFF, {16'h0, r[15:0]});
      chk(ADDR_TSHR, 32'hFFFF_FFFF, {16'h0, ~r[15:0]});
    end
    // Enable set, disable set, zero writes change nothing
    wr(ADDR_IER, 32'hFFFF_FFFF);
    chk(ADDR_IMR, 32'hFFFF_FFFF, IRQ_BITS);
    r = $random(seed);
    wr(ADDR_IDR, r);
    chk(ADDR_IMR, 32'hFFFF_FFFF, IRQ_BITS & ~r);
    wr(ADDR_IER, 32'h0);
    chk(ADDR_IMR, 32'hFFFF_FFFF, IRQ_BITS & ~r);
    wr(ADDR_IDR, 32'hFFFF_FFFF);
    chk(ADDR_IMR, 32'hFFFF_FFFF, 32'h0);
    // Receive word raises the interrupt with its source enabled; reading it drops the interrupt
    wr(ADDR_IER, 32'h1 << SR_RX_READY);
    w = $random(seed);
    ssd_far_model_inst.rx_deliver(w);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    chk(ADDR_RHR, 32'hFFFF_FFFF, w);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_IDR, 32'hFFFF_FFFF);
    // Two words without a read in between: overrun, cleared by status read
    ssd_far_model_inst.rx_deliver(~w);
    ssd_far_model_inst.rx_deliver(w);
    chk(ADDR_SR, 32'h30, 32'h30);
    chk(ADDR_SR, 32'h30, 32'h10);
    chk(ADDR_RHR, 32'hFFFF_FFFF, w);
    chk(ADDR_SR, 32'h10, 32'h0);
    // Receive frame sync seen once, then cleared by the read
    ssd_far_model_inst.rx_sync();
    chk(ADDR_SR, 32'h800, 32'h800);
    chk(ADDR_SR, 32'h800, 32'h0);
    // Counter levels per direction: done flag, both-zero flag, write clears done
    for (int dir = 0; dir < 2; dir++) begin
      ssd_far_model_inst.dma_set(dir[0], 1'b1, 1'b0);
      repeat (3) @(posedge clock);
      chk(ADDR_SR, dir ? 32'hC0 : 32'hC, dir ? 32'h40 : 32'h4);
      ssd_far_model_inst.dma_set(dir[0], 1'b1, 1'b1);
      chk(ADDR_SR, dir ? 32'hC0 : 32'hC, dir ? 32'hC0 : 32'hC);
      ssd_far_model_inst.dma_set(dir[0], 1'b0, 1'b0);
      ssd_far_model_inst.dma_wr(dir[0]);
      repeat (3) @(posedge clock);
      chk(ADDR_SR, dir ? 32'hC0 : 32'hC, 32'h0);
    end
    // Directions off: a written word waits and nothing is framed
    wr(ADDR_CTRL, 32'h0003_070C);
    chk(ADDR_SR, 32'h0003_0000, 32'h0);
    wr(ADDR_THR, $random(seed));
    ssd_far_model_inst.link_run(13);
    check({19'h0, seen_frame[12:0]}, 32'h0);
    chk(ADDR_SR, 32'h3, 32'h0);
    // Framed word, with and without sync data
    for (int sden = 1; sden >= 0; sden--) begin
      wr(ADDR_CTRL, 32'h0003_070B | (sden << CTRL_SDEN));
      r = $random(seed);
      w = $random(seed);
      wr(ADDR_TSHR, r);
      wr(ADDR_THR, w);
      chk(ADDR_SR, 32'h0003_0003, 32'h0003_0000);
      ssd_far_model_inst.link_run(13);
      check({19'h0, seen_data[12:0]}, {19'h0, exp_frame(sden[0], r[3:0], w[7:0])});
      check({19'h0, seen_frame[12:0]}, 32'h1E00);
      repeat (5) @(posedge clock);
      chk(ADDR_SR, 32'h403, 32'h403);
      chk(ADDR_SR, 32'h400, 32'h0);
    end
    tally_and_finish();
  end
endmodule
